// ---- verilog/pmb_pkg.sv ----
// Shared constants for the PLL manual/automatic bandwidth control block
package pmb_pkg;
	// ****************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [7:0] PMB_OFS_CTRL = 8'h00; // Control and bandwidth bits
	localparam logic [7:0] PMB_OFS_MULT = 8'h04; // VCO multiplier
	localparam logic [7:0] PMB_OFS_STAT = 8'h08; // Sticky events, cleared by read
	localparam logic [7:0] PMB_OFS_MASK = 8'h0C; // Interrupt mask
	localparam logic [7:0] PMB_OFS_PER = 8'h10; // Measured reference period
	// ****************************************************************
	// Field positions in the control word
	// ****************************************************************
	localparam int PMB_BIT_PON = 0; // pll_power_on
	localparam int PMB_BIT_BCS = 1; // base_clock_select
	localparam int PMB_BIT_AUTO = 2; // Automatic bandwidth select
	localparam int PMB_BIT_ACQ = 3; // acquisition_tracking_select
	localparam int PMB_BIT_LOCK = 4; // Lock status, read only
	// Event bits in status and mask
	localparam int PMB_EV_TRK = 0; // Filter entered tracking by hardware
	localparam int PMB_EV_LOCK = 1; // Lock reached
	localparam int PMB_EV_N = 2;
	// ****************************************************************
	// Widths, reset values and ratios
	// ****************************************************************
	localparam int PMB_MULT_W = 8;
	localparam int PMB_CNT_W = 16;
	localparam logic [PMB_MULT_W-1:0] PMB_MULT_RST = 8'h08; // Reset multiplier
	localparam logic [1:0] PMB_BUS_DIV_LAST = 2'h3; // VCO divided by four
	localparam int PMB_VCO_PER_BUS = 4; // VCO runs at four times bus rate
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int PMB_CLK_PERIOD_PS = 8000; // 125 MHz
	localparam int PMB_ACQ_TIME_NS = 20000; // acquisition_wait_time, auto mode
	localparam int PMB_ACQ_CYC = (PMB_ACQ_TIME_NS * 1000 + PMB_CLK_PERIOD_PS - 1) / PMB_CLK_PERIOD_PS;
	// ****************************************************************
	// Sequencer states for automatic bandwidth mode
	// ****************************************************************
	typedef enum logic [3:0] {
		PMB_ST_OFF = 4'b0001,
		PMB_ST_ACQ = 4'b0010,
		PMB_ST_TRK = 4'b0100,
		PMB_ST_LOCK = 4'b1000
	} pmb_state_type;
endpackage : pmb_pkg

// ---- verilog/pmb_pll_ctrl.sv ----
// PLL bandwidth control, VCO rate model and bus clock divider with APB registers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pmb_pll_ctrl import pmb_pkg::*; #(
	parameter int LOCK_TIME_NS = 50000 // Lock time in automatic mode
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce, // Freezes all state while low
	input wire logic ref_clk_pin, // Reference crystal clock, asynchronous
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pll_power_on, // Analog enable
	output logic loop_filter_tracking, // Filter mode, high for tracking
	output logic lock_status,
	output logic vco_tick, // One pulse per VCO period
	output logic bus_tick, // One pulse per generated clock period
	output logic irq
);
	// ****************************************************************
	// Derived timing
	// ****************************************************************
	localparam int LOCK_CYC = (LOCK_TIME_NS * 1000 + PMB_CLK_PERIOD_PS - 1) / PMB_CLK_PERIOD_PS;
	localparam logic [PMB_CNT_W-1:0] ACQ_CNT = PMB_CNT_W'(PMB_ACQ_CYC);
	localparam logic [PMB_CNT_W-1:0] LOCK_CNT = PMB_CNT_W'(LOCK_CYC);

	// Word decode shared by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic ref_s1_q, ref_s2_q, ref_s3_q; // Reference synchroniser and edge flop
	logic ref_rise; // Reference rising edge
	logic [PMB_CNT_W-1:0] per_cnt_q, per_cnt_d; // Cycles since last edge
	logic [PMB_CNT_W-1:0] per_q, per_d; // Last measured period
	logic [PMB_CNT_W-1:0] acc_q, acc_d; // Rate accumulator
	logic vco_q, vco_d, bus_q, bus_d; // Pulse registers
	logic [1:0] div_q, div_d; // VCO to bus divider
	logic pon_q, pon_d, bcs_q, bcs_d, auto_q, auto_d, acq_q, acq_d;
	logic [PMB_MULT_W-1:0] mult_q, mult_d;
	pmb_state_type st_q, st_d;
	logic [PMB_CNT_W-1:0] tmr_q, tmr_d; // Time since power-on in auto mode
	logic [PMB_EV_N-1:0] stat_q, stat_d, mask_q, mask_d, ev_set;
	logic [31:0] rd_q, rd_d;
	logic setup, wr, rd, mapped;
	logic [PMB_CNT_W:0] acc_sum; // One bit wider to catch overflow

	// ****************************************************************
	// Reference synchroniser, first flop feeds only the second
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
		end else if (ce) begin
			ref_s1_q <= ref_clk_pin;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end
	assign ref_rise = ref_s2_q & ~ref_s3_q;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	// Unmapped offsets answer with an error
	assign mapped = hit(paddr, PMB_OFS_CTRL) | hit(paddr, PMB_OFS_MULT) | hit(paddr, PMB_OFS_STAT)
		| hit(paddr, PMB_OFS_MASK) | hit(paddr, PMB_OFS_PER);
	assign pready = 1'b1; // Zero wait states
	assign pslverr = psel & penable & ~mapped;

	// ****************************************************************
	// Next-state logic for registers, sequencer and clock model
	// ****************************************************************
	always_comb begin
		pon_d = pon_q;
		bcs_d = bcs_q;
		auto_d = auto_q;
		acq_d = acq_q;
		mult_d = mult_q;
		mask_d = mask_q;
		st_d = st_q;
		tmr_d = tmr_q;
		ev_set = '0;
		rd_d = rd_q;
		// Software writes to control, multiplier and mask
		if (wr && hit(paddr, PMB_OFS_CTRL)) begin
			pon_d = pwdata[PMB_BIT_PON];
			bcs_d = pwdata[PMB_BIT_BCS];
			auto_d = pwdata[PMB_BIT_AUTO];
			// Filter select is software's only in manual mode
			if (!pwdata[PMB_BIT_AUTO]) begin
				acq_d = pwdata[PMB_BIT_ACQ];
			end
		end
		if (wr && hit(paddr, PMB_OFS_MULT)) begin
			mult_d = pwdata[PMB_MULT_W-1:0]; // Keeps only the low eight bits of the written word
		end
		if (wr && hit(paddr, PMB_OFS_MASK)) begin
			mask_d = pwdata[PMB_EV_N-1:0];
		end
		// Automatic bandwidth sequencer, idle in manual mode
		if (!pon_q || !auto_q) begin
			st_d = PMB_ST_OFF;
			tmr_d = '0;
		end else begin
			if (tmr_q != LOCK_CNT) begin
				tmr_d = tmr_q + 1'b1;
			end
			case (st_q)
				PMB_ST_OFF: st_d = PMB_ST_ACQ; // Start acquiring
				PMB_ST_ACQ: begin
					// Hardware moves the filter to tracking
					if (tmr_q >= ACQ_CNT) begin
						st_d = PMB_ST_TRK;
						ev_set[PMB_EV_TRK] = 1'b1;
					end
				end
				PMB_ST_TRK: begin
					// Lock reported once the lock time has run
					if (tmr_q >= LOCK_CNT) begin
						st_d = PMB_ST_LOCK;
						ev_set[PMB_EV_LOCK] = 1'b1;
					end
				end
				PMB_ST_LOCK: st_d = PMB_ST_LOCK; // Stays locked until off
				default: st_d = PMB_ST_OFF; // Unknown code, restart
			endcase
		end
		// Hardware drives the select bit in auto mode, unless software is leaving it
		if (auto_q && !(wr && hit(paddr, PMB_OFS_CTRL) && !pwdata[PMB_BIT_AUTO])) begin
			acq_d = (st_d == PMB_ST_TRK) || (st_d == PMB_ST_LOCK);
		end
		// Sticky events: a read clears only the bits it reported at setup,
		// so an event between setup and access is not lost; a set still wins
		stat_d = stat_q;
		if (rd && hit(paddr, PMB_OFS_STAT)) begin
			stat_d = stat_q & ~rd_q[PMB_EV_N-1:0];
		end
		stat_d = stat_d | ev_set;
		// Read data captured in the setup phase
		if (setup) begin
			rd_d = '0;
			if (hit(paddr, PMB_OFS_CTRL)) begin
				rd_d[PMB_BIT_LOCK:PMB_BIT_PON] = {lock_status, acq_q, auto_q, bcs_q, pon_q}; // Adjacent fields
			end else if (hit(paddr, PMB_OFS_MULT)) begin
				rd_d[PMB_MULT_W-1:0] = mult_q;
			end else if (hit(paddr, PMB_OFS_STAT)) begin
				rd_d[PMB_EV_N-1:0] = stat_q;
			end else if (hit(paddr, PMB_OFS_MASK)) begin
				rd_d[PMB_EV_N-1:0] = mask_q;
			end else if (hit(paddr, PMB_OFS_PER)) begin
				rd_d[PMB_CNT_W-1:0] = per_q;
			end
		end
		// Reference period measurement, the edge counter saturating
		per_cnt_d = per_cnt_q;
		per_d = per_q;
		if (ref_rise) begin
			per_d = per_cnt_q + 1'b1;
			per_cnt_d = '0;
		end else if (per_cnt_q != '1) begin
			per_cnt_d = per_cnt_q + 1'b1;
		end
		// VCO at multiplier times reference: add N per cycle, wrap at period.
		// Limitation: at most one VCO pulse per system clock.
		acc_sum = {1'b0, acc_q} + {{(PMB_CNT_W + 1 - PMB_MULT_W){1'b0}}, mult_q};
		acc_d = acc_q;
		vco_d = 1'b0;
		if (pon_q && per_q != '0) begin
			if (acc_sum >= {1'b0, per_q}) begin
				acc_d = PMB_CNT_W'(acc_sum - {1'b0, per_q});
				vco_d = 1'b1;
			end else begin
				acc_d = acc_sum[PMB_CNT_W-1:0];
			end
		end else begin
			acc_d = '0;
		end
		// Generated clock: VCO over four when selected and powered on, else the reference
		div_d = div_q;
		bus_d = 1'b0;
		if (bcs_q && pon_q) begin
			if (vco_q) begin
				div_d = div_q + 1'b1;
				bus_d = (div_q == PMB_BUS_DIV_LAST);
			end
		end else begin
			div_d = '0;
			bus_d = ref_rise;
		end
	end

	// ****************************************************************
	// State registers
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			{pon_q, bcs_q, auto_q, acq_q, vco_q, bus_q} <= '0; // Select clear, power-on starts acquiring
			{per_cnt_q, per_q, acc_q, tmr_q, rd_q} <= '0;
			{mask_q, stat_q, div_q} <= '0;
			mult_q <= PMB_MULT_RST;
			st_q <= PMB_ST_OFF;
		end else if (ce) begin
			{pon_q, bcs_q, auto_q, acq_q, vco_q, bus_q} <= {pon_d, bcs_d, auto_d, acq_d, vco_d, bus_d};
			{per_cnt_q, per_q, acc_q, tmr_q, rd_q} <= {per_cnt_d, per_d, acc_d, tmr_d, rd_d};
			{mask_q, stat_q, div_q} <= {mask_d, stat_d, div_d};
			mult_q <= mult_d;
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = rd_q;
	assign pll_power_on = pon_q;
	assign loop_filter_tracking = acq_q;
	assign lock_status = auto_q & (st_q == PMB_ST_LOCK);
	assign irq = auto_q & |(stat_q & mask_q);
	assign vco_tick = vco_q;
	assign bus_tick = bus_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_manual_no_lock;
		@(posedge clock) disable iff (srst) !auto_q |-> !lock_status;
	endproperty
	a_manual_no_lock: assert property (p_manual_no_lock) else $error("lock shown in manual mode");
	property p_manual_no_irq;
		@(posedge clock) disable iff (srst) !auto_q |-> !irq;
	endproperty
	a_manual_no_irq: assert property (p_manual_no_irq) else $error("irq in manual mode");
	property p_manual_acq_write;
		@(posedge clock) disable iff (srst)
			ce && wr && hit(paddr, PMB_OFS_CTRL) && !pwdata[PMB_BIT_AUTO]
			|=> loop_filter_tracking == $past(pwdata[PMB_BIT_ACQ]);
	endproperty
	a_manual_acq_write: assert property (p_manual_acq_write) else $error("filter select not written");
	property p_manual_hold;
		@(posedge clock) disable iff (srst) ce && !auto_q && !wr |=> $stable(loop_filter_tracking);
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("filter select moved by itself");
	property p_lock_time;
		@(posedge clock) disable iff (srst) $rose(lock_status) |-> tmr_q == LOCK_CNT;
	endproperty
	a_lock_time: assert property (p_lock_time) else $error("lock before lock time");
	property p_acq_time;
		@(posedge clock) disable iff (srst) auto_q && $rose(loop_filter_tracking) |-> tmr_q > ACQ_CNT;
	endproperty
	a_acq_time: assert property (p_acq_time) else $error("tracking before acquisition time");
	property p_bus_div;
		@(posedge clock) disable iff (srst)
			ce && bcs_q && pon_q && vco_q && div_q == PMB_BUS_DIV_LAST |=> bus_tick;
	endproperty
	a_bus_div: assert property (p_bus_div) else $error("bus tick missing after fourth vco pulse");
	property p_bus_only_from_vco;
		@(posedge clock) disable iff (srst) ce && bcs_q && pon_q && !vco_q |=> !bus_tick;
	endproperty
	a_bus_only_from_vco: assert property (p_bus_only_from_vco) else $error("bus tick without vco");
	property p_vco_off;
		@(posedge clock) disable iff (srst) ce && !pon_q |=> !vco_tick;
	endproperty
	a_vco_off: assert property (p_vco_off) else $error("vco runs while powered down");

endmodule : pmb_pll_ctrl

`default_nettype wire

// ---- sim/pll_manual_bandwidth_setup_bench.sv ----
// Self-checking bench for the PLL bandwidth control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pll_manual_bandwidth_setup_bench;
	import pmb_pkg::*;
	// ****************************************************************
	// Signals and design instance
	// ****************************************************************
	localparam int LOCK_NS = 24000; // Lock later than acquisition
	localparam int LOCK_CYC = LOCK_NS / 8; // 3000 clocks
	localparam int REF_HALF = 16; // Reference period of 32 clocks
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1; // Clock enable, dropped once to check the freeze
	logic ref_clk_pin = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pll_power_on, loop_filter_tracking, lock_status;
	logic vco_tick, bus_tick, irq, err;
	int err_total = 0, cmp_count = 0, ref_div = 0, nv, nb, n;

	pmb_pll_ctrl #(.LOCK_TIME_NS(LOCK_NS)) pmb_pll_ctrl_inst (
		.clock(clock), .srst(srst), .ce(ce), .ref_clk_pin(ref_clk_pin),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pll_power_on(pll_power_on), .loop_filter_tracking(loop_filter_tracking),
		.lock_status(lock_status), .vco_tick(vco_tick), .bus_tick(bus_tick), .irq(irq)
	);

	// Clock at 125 MHz
	initial begin
		forever #4 clock = ~clock;
	end

	// Reference crystal made from the system clock, far below half rate
	always @(posedge clock) begin
		ref_div <= (ref_div == REF_HALF - 1) ? 0 : ref_div + 1;
		if (ref_div == REF_HALF - 1) ref_clk_pin <= ~ref_clk_pin;
	end

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	// One APB transfer; waits for pready as long as it takes, only the watchdog ends a stuck slave
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(negedge clock); // Let register updates land before checks
	endtask : apb

	// Counts VCO and bus pulses over a window of clocks
	task automatic count_ticks(input int cyc);
		nv = 0; nb = 0;
		repeat (cyc) begin
			@(posedge clock);
			nv += (vco_tick === 1'b1);
			nb += (bus_tick === 1'b1);
		end
	endtask : count_ticks

	// Waits for a level on a design output, returns the clocks spent
	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_hi

	function automatic logic in_rng(input int v, input int lo, input int hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_rng

	// Single end of run for tests and watchdog
	task automatic print_verdict;
		$display("mismatches %0d of %0d comparisons", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict

	// Watchdog, well beyond the roughly 6500 clocks the tests need
	initial begin
		#400000;
		err_total++;
		print_verdict();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		// Reset values
		`CHK({pll_power_on, loop_filter_tracking, lock_status, irq, pready}, 5'h01)
		apb(1'b0, PMB_OFS_CTRL, 32'h0); `CHK(rd, 32'h00000000)
		apb(1'b0, PMB_OFS_MULT, 32'h0); `CHK(rd, 32'h00000008)
		// Unmapped place refused
		apb(1'b1, 8'h14, 32'hFFFFFFFF); `CHK(err, 1'b1)
		apb(1'b0, 8'h14, 32'h0); `CHK({err, rd}, {1'b1, 32'h00000000})
		// Multiplier 4; unused upper bits read as zero
		apb(1'b1, PMB_OFS_MULT, 32'hFFFFFF04);
		apb(1'b0, PMB_OFS_MULT, 32'h0); `CHK(rd, 32'h00000004)
		apb(1'b1, PMB_OFS_MASK, 32'h00000003);
		// Manual start: select clear, then power on
		apb(1'b1, PMB_OFS_CTRL, 32'h00000000);
		apb(1'b1, PMB_OFS_CTRL, 32'h00000001);
		`CHK({pll_power_on, loop_filter_tracking}, 2'b10)
		repeat (PMB_ACQ_CYC + 10) @(posedge clock);
		@(negedge clock);
		// No hardware tracking, lock or interrupt in manual mode
		`CHK({loop_filter_tracking, lock_status, irq}, 3'b000)
		apb(1'b1, PMB_OFS_CTRL, 32'h00000009);
		`CHK(loop_filter_tracking, 1'b1)
		apb(1'b0, PMB_OFS_PER, 32'h0); `CHK(rd, 32'h00000020)
		// Reference as base clock: one bus pulse per reference period
		count_ticks(256);
		`CHK(in_rng(nv, 31, 33), 1'b1)
		`CHK(in_rng(nb, 7, 9), 1'b1)
		repeat (100) @(posedge clock); // Settle wait before switching
		apb(1'b1, PMB_OFS_CTRL, 32'h0000000B);
		count_ticks(256);
		`CHK(in_rng(nv, 31, 33), 1'b1)
		`CHK(in_rng(nb, 7, 9), 1'b1)
		`CHK(in_rng(nv, 4 * nb - 4, 4 * nb + 4), 1'b1)
		apb(1'b0, PMB_OFS_STAT, 32'h0); `CHK(rd, 32'h00000000)
		`CHK({lock_status, irq}, 2'b00)
		// Multiplier 6 changes the VCO rate
		apb(1'b1, PMB_OFS_MULT, 32'h00000006);
		repeat (64) @(posedge clock);
		count_ticks(256);
		`CHK(in_rng(nv, 47, 49), 1'b1)
		`CHK(in_rng(nb, 11, 13), 1'b1)
		// Clock enable low freezes all state: a write then has no effect
		@(posedge clock);
		ce <= 1'b0;
		apb(1'b1, PMB_OFS_CTRL, 32'h00000000);
		@(posedge clock);
		ce <= 1'b1;
		@(negedge clock);
		`CHK({pll_power_on, loop_filter_tracking}, 2'b11)
		// Automatic mode from power off
		apb(1'b1, PMB_OFS_CTRL, 32'h00000000);
		apb(1'b1, PMB_OFS_CTRL, 32'h00000005);
		wait_hi(loop_filter_tracking, 4000);
		`CHK(in_rng(n, PMB_ACQ_CYC - 8, PMB_ACQ_CYC + 8), 1'b1)
		`CHK(lock_status, 1'b0)
		wait_hi(lock_status, 2000);
		`CHK(in_rng(n + PMB_ACQ_CYC, LOCK_CYC - 16, LOCK_CYC + 16), 1'b1)
		@(negedge clock);
		`CHK(irq, 1'b1)
		apb(1'b0, PMB_OFS_CTRL, 32'h0); `CHK(rd, 32'h0000001D)
		apb(1'b0, PMB_OFS_STAT, 32'h0); `CHK(rd, 32'h00000003)
		`CHK(irq, 1'b0)
		// Back to manual: lock indicator off at once
		apb(1'b1, PMB_OFS_CTRL, 32'h00000001);
		`CHK({lock_status, irq}, 2'b00)
		apb(1'b0, PMB_OFS_CTRL, 32'h0); `CHK(rd[4], 1'b0)
		print_verdict();
	end
endmodule : pll_manual_bandwidth_setup_bench

`default_nettype wire
